// >>> verilog/tbc_timer_pair.sv
// tbc_timer_pair: an even/odd pair of 16-bit type B timers, joinable into
// one 32-bit timer, with control, count, period and interrupt registers.
// assumes: classic Wishbone master on clk_i; count clock and gate pins are
// asynchronous; idle_i comes from on-chip logic on clk_i.
`default_nettype none

// Function
// - timer counts only while its enable bit is one.
// - stop-in-idle set halts the timer while the device is idle.
// - with external clock, gating is ignored and reads back zero.
// - with internal clock, gate enable selects gated time accumulation.
// - prescale select divides input by 1,2,4,8,16,32,64 or 256.
// - wide-mode bit joins even and odd timers into one 32-bit timer.
// - wide-mode bit exists only in the even timer control register.
// - in wide mode odd enable, gate, prescale, source bits do nothing.
// - in wide mode odd stop-in-idle still halts the pair when idle.
// - source select one counts the external pin, zero internal clock.
// - unimplemented control bits ignore writes and read as zero.
module tbc_timer_pair (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device state
  input wire logic idle_i,
  // pins, index 0 even timer, 1 odd timer
  input wire logic [1:0] ext_count_clock_pin_i,
  input wire logic [1:0] gate_pin_i,
  // interrupt
  output logic irq_o
);
  import tbc_pkg::*;

  logic [15:0] ctrl_e, ctrl_o;
  logic [15:0] count_e, count_o, period_e, period_o;
  logic [STAT_W-1:0] status, int_mask;
  logic [1:0] ext_m, ext_s, ext_d, gate_m, gate_s, gate_d;
  logic [1:0] ext_rise, gate_fall;
  logic req, wr, rd;
  logic [7:0] adr;
  logic wide, run_e, run_o, cs_e, cs_o, gated_e, gated_o;
  logic raw_e, raw_o, tick_e, tick_o;
  logic match_e, match_o, pend_e, pend_o;
  logic [STAT_W-1:0] ev;
  logic [31:0] next_rdata;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] ctrl_view(input logic [15:0] c);
    ctrl_view = c;
    if (c[BIT_CS]) begin
      ctrl_view[BIT_GATE] = 1'b0;
    end
  endfunction

  // bus decode; one-cycle answer, unmapped reads zero
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_m <= 2'b00;
      ext_s <= 2'b00;
      ext_d <= 2'b00;
      gate_m <= 2'b00;
      gate_s <= 2'b00;
      gate_d <= 2'b00;
    end else begin
      ext_m <= ext_count_clock_pin_i;
      ext_s <= ext_m;
      ext_d <= ext_s;
      gate_m <= gate_pin_i;
      gate_s <= gate_m;
      gate_d <= gate_s;
    end
  end

  assign ext_rise = ext_s & ~ext_d;
  assign gate_fall = gate_d & ~gate_s;

  assign wide = ctrl_e[BIT_WIDE];
  assign run_e = ctrl_e[BIT_ON] & ~(idle_i & ctrl_e[BIT_STOP_IN_IDLE_SEL])
               & ~(wide & idle_i & ctrl_o[BIT_STOP_IN_IDLE_SEL]);
  assign run_o = ~wide & ctrl_o[BIT_ON] & ~(idle_i & ctrl_o[BIT_STOP_IN_IDLE_SEL]);
  assign cs_e = ctrl_e[BIT_CS];
  assign cs_o = ctrl_o[BIT_CS];
  assign gated_e = ctrl_e[BIT_GATE] & ~cs_e;
  assign gated_o = ctrl_o[BIT_GATE] & ~cs_o;
  assign raw_e = run_e & (cs_e ? ext_rise[0] : 1'b1)
               & (~gated_e | gate_s[0]);
  assign raw_o = run_o & (cs_o ? ext_rise[1] : 1'b1)
               & (~gated_o | gate_s[1]);

  tbc_prescale u_ps_even (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(~run_e),
    .sel_i(ctrl_e[PS_LSB +: PS_W]),
    .tick_i(raw_e),
    .tick_o(tick_e)
  );

  tbc_prescale u_ps_odd (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(~run_o),
    .sel_i(ctrl_o[PS_LSB +: PS_W]),
    .tick_i(raw_o),
    .tick_o(tick_o)
  );

  assign match_e = wide ? ({count_o, count_e} == {period_o, period_e})
                        : (count_e == period_e);
  assign match_o = (count_o == period_o);

  // control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_e <= CTRL_RST;
      ctrl_o <= CTRL_RST;
    end else if (wr) begin
      if (adr == ADR_CTRL_EVEN) begin
        ctrl_e <= merge16(ctrl_e, wb_dat_i, wb_sel_i) & CTRL_MASK_EVEN;
      end
      if (adr == ADR_CTRL_ODD) begin
        ctrl_o <= merge16(ctrl_o, wb_dat_i, wb_sel_i) & CTRL_MASK_ODD;
      end
    end
  end

  // period registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      period_e <= PERIOD_RST;
      period_o <= PERIOD_RST;
    end else if (wr) begin
      if (adr == ADR_PERIOD_EVEN) begin
        period_e <= merge16(period_e, wb_dat_i, wb_sel_i);
      end
      if (adr == ADR_PERIOD_ODD) begin
        period_o <= merge16(period_o, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_e <= COUNT_RST;
    end else if (wr && adr == ADR_COUNT_EVEN) begin
      count_e <= merge16(count_e, wb_dat_i, wb_sel_i);
    end else if (tick_e) begin
      count_e <= match_e ? COUNT_RST : count_e + 16'h0001;
    end
  end

  // odd half carries in wide mode
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= COUNT_RST;
    end else if (wr && adr == ADR_COUNT_ODD) begin
      count_o <= merge16(count_o, wb_dat_i, wb_sel_i);
    end else if (wide) begin
      if (tick_e) begin
        if (match_e) begin
          count_o <= COUNT_RST;
        end else if (count_e == COUNT_TOP) begin
          count_o <= count_o + 16'h0001;
        end
      end
    end else if (tick_o) begin
      count_o <= match_o ? COUNT_RST : count_o + 16'h0001;
    end
  end

  assign pend_e = (tick_e & match_e & ~gated_e)
                | (gate_fall[0] & run_e & gated_e);
  assign pend_o = (tick_o & match_o & ~gated_o)
                | (gate_fall[1] & run_o & gated_o);
  // the joined pair reports on the odd flag, as the upper half does
  assign ev[STAT_EVEN] = ~wide & pend_e;
  assign ev[STAT_ODD] = wide ? pend_e : pend_o;

  // sticky status: an event in the clearing read's cycle survives
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status <= '0;
    end else if (rd && adr == ADR_INT_STATUS) begin
      status <= ev;
    end else begin
      status <= status | ev;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_mask <= '0;
    end else if (wr && adr == ADR_INT_MASK && wb_sel_i[0]) begin
      int_mask <= wb_dat_i[STAT_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & int_mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (adr)
      ADR_CTRL_EVEN: next_rdata[15:0] = ctrl_view(ctrl_e);
      ADR_CTRL_ODD: next_rdata[15:0] = ctrl_view(ctrl_o);
      ADR_COUNT_EVEN: next_rdata[15:0] = count_e;
      ADR_COUNT_ODD: next_rdata[15:0] = count_o;
      ADR_PERIOD_EVEN: next_rdata[15:0] = period_e;
      ADR_PERIOD_ODD: next_rdata[15:0] = period_o;
      ADR_INT_STATUS: next_rdata[STAT_W-1:0] = status;
      ADR_INT_MASK: next_rdata[STAT_W-1:0] = int_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // checks
  logic wr_cnt;
  assign wr_cnt = wr && (adr == ADR_COUNT_EVEN || adr == ADR_COUNT_ODD);

  off_holds_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !ctrl_e[BIT_ON] && !wr_cnt |=> $stable(count_e))
    else $error("even count moved while disabled");

  idle_stop_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    idle_i && ctrl_e[BIT_STOP_IN_IDLE_SEL] && !wr_cnt |=> $stable(count_e))
    else $error("even count moved in idle with stop set");

  gate_reads_zero_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    rd && adr == ADR_CTRL_EVEN && ctrl_e[BIT_CS] |=> !wb_dat_o[BIT_GATE])
    else $error("gate bit read as one with external clock");

  gate_low_hold_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    gated_e && !gate_s[0] && !wr_cnt |=> $stable(count_e))
    else $error("gated count moved with gate low");

  unit_step_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    run_e && !cs_e && !gated_e && !wide && !wr_cnt && !match_e
    && ctrl_e[PS_LSB +: PS_W] == 3'h0
    |=> count_e == $past(count_e) + 16'h0001)
    else $error("1:1 prescale did not step every cycle");

  odd_no_wide_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !ctrl_o[BIT_WIDE])
    else $error("odd control holds a wide-mode bit");

  odd_ignored_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wide && !tick_e && !wr_cnt |=> $stable(count_o))
    else $error("odd half moved without an even tick");

  odd_idle_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wide && idle_i && ctrl_o[BIT_STOP_IN_IDLE_SEL] && !wr_cnt
    |=> $stable({count_o, count_e}))
    else $error("pair ran in idle with odd stop set");

  ctrl_unimpl_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    rd && (adr == ADR_CTRL_EVEN || adr == ADR_CTRL_ODD)
    |=> (wb_dat_o & ~{16'h0000, CTRL_MASK_EVEN}) == 32'h0000_0000)
    else $error("unimplemented control bit read as one");

  wrap_flag_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    tick_e && match_e && !gated_e && !wide && !wr_cnt
    |=> count_e == COUNT_RST ##1 (irq_o || !int_mask[STAT_EVEN]))
    else $error("period match did not wrap or interrupt");

  fall_flag_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    gate_fall[0] && run_e && gated_e && !wide
    |=> status[STAT_EVEN])
    else $error("gate fall did not set the flag");

  carry_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wide && tick_e && !match_e && count_e == COUNT_TOP && !wr_cnt
    |=> count_o == $past(count_o) + 16'h0001)
    else $error("odd half missed the carry");

  odd_wrap_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    tick_o && match_o && !wide && !wr_cnt |=> count_o == COUNT_RST)
    else $error("odd count did not wrap at its period");

  pair_flag_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wide && tick_e && match_e && !gated_e |=> status[STAT_ODD])
    else $error("pair period match did not set the odd flag");

endmodule // tbc_timer_pair

`default_nettype wire

// >>> verilog/tbc_pkg.sv
// tbc_pkg: register map, field positions, reset values and prescale limits
// for the paired type B timer control block.
// assumes: a classic Wishbone slave decodes byte addresses 7:2.
`default_nettype none

package tbc_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_CTRL_EVEN = 8'h00;
  localparam logic [7:0] ADR_COUNT_EVEN = 8'h10;
  localparam logic [7:0] ADR_PERIOD_EVEN = 8'h20;
  localparam logic [7:0] ADR_CTRL_ODD = 8'h40;
  localparam logic [7:0] ADR_COUNT_ODD = 8'h50;
  localparam logic [7:0] ADR_PERIOD_ODD = 8'h60;
  localparam logic [7:0] ADR_INT_STATUS = 8'h80;
  localparam logic [7:0] ADR_INT_MASK = 8'h84;

  // timer_control field positions
  localparam int BIT_ON = 15;
  localparam int BIT_STOP_IN_IDLE_SEL = 13;
  localparam int BIT_GATE = 7;
  localparam int PS_LSB = 4;
  localparam int PS_W = 3;
  localparam int BIT_WIDE = 3;
  localparam int BIT_CS = 1;

  // implemented bits; the odd control word has no wide-mode bit
  localparam logic [15:0] CTRL_MASK_EVEN = 16'hA0FA;
  localparam logic [15:0] CTRL_MASK_ODD = 16'hA0F2;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;

  // interrupt status / mask layout
  localparam int STAT_W = 2;
  localparam int STAT_EVEN = 0;
  localparam int STAT_ODD = 1;

  // prescaler terminal counts for sel 0..7 (1,2,4,8,16,32,64,256)
  localparam logic [7:0] PS_LIMIT [8] = '{8'h00, 8'h01, 8'h03, 8'h07,
                                         8'h0F, 8'h1F, 8'h3F, 8'hFF};

endpackage

`default_nettype wire

// >>> verilog/tbc_prescale.sv
// tbc_prescale: divides a stream of input ticks by 1..256.
// assumes: tick_i is a one-cycle enable on clk_i; clear_i while disabled.
`default_nettype none

module tbc_prescale (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic clear_i,
  input wire logic [tbc_pkg::PS_W-1:0] sel_i,
  // ticks
  input wire logic tick_i,
  output logic tick_o
);
  import tbc_pkg::*;

  logic [7:0] cnt;
  logic at_limit;

  assign at_limit = (cnt >= PS_LIMIT[sel_i]);
  assign tick_o = tick_i & at_limit;

  // clearing on disable gives a full first period after enable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 8'h00;
    end else if (clear_i) begin
      cnt <= 8'h00;
    end else if (tick_i) begin
      cnt <= at_limit ? 8'h00 : cnt + 8'h01;
    end
  end

endmodule // tbc_prescale

`default_nettype wire

// >>> verification/tb_type_b_timer_control.sv
// tb_type_b_timer_control: self-checking bench for the paired timer block.
// assumes: tbc_pkg and tbc_timer_pair compiled first; one 20 MHz clock.
`default_nettype none
`define CHK(got, exp) chk(32'(got), 32'(exp))

module tb_type_b_timer_control;
  timeunit 1ns;
  timeprecision 1ns;
  import tbc_pkg::*;

  localparam logic [31:0] C_ON = 32'(1) << BIT_ON;
  localparam logic [31:0] C_STOP_IN_IDLE_SEL = 32'(1) << BIT_STOP_IN_IDLE_SEL;
  localparam logic [31:0] C_GATE = 32'(1) << BIT_GATE;
  localparam logic [31:0] C_WIDE = 32'(1) << BIT_WIDE;
  localparam logic [31:0] C_CS = 32'(1) << BIT_CS;

  logic clk_i;
  logic reset_n_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic idle;
  logic [1:0] ext_pin;
  logic [1:0] gate_pin;
  logic irq;
  logic [31:0] q;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int divs [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  logic [7:0] ra [8] = '{ADR_CTRL_EVEN, ADR_COUNT_EVEN, ADR_PERIOD_EVEN,
    ADR_CTRL_ODD, ADR_COUNT_ODD, ADR_PERIOD_ODD, ADR_INT_STATUS, ADR_INT_MASK};
  logic [15:0] rv [8] = '{CTRL_RST, COUNT_RST, PERIOD_RST, CTRL_RST,
    COUNT_RST, PERIOD_RST, 16'h0000, 16'h0000};

  tbc_timer_pair DUT (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack),
    .idle_i(idle),
    .ext_count_clock_pin_i(ext_pin),
    .gate_pin_i(gate_pin),
    .irq_o(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic in_rng(input logic [31:0] v, input int lo,
                                  input int hi);
    return (v >= lo) && (v <= hi);
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 16);
    `CHK(wb_ack, 1'b1);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // hang guard: whole sequence needs well under 10k cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h3;
    wb_dat_w = 32'h0000_0000;
    idle = 1'b0;
    ext_pin = 2'b00;
    gate_pin = 2'b00;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], q);
      `CHK(q, {16'h0000, rv[i]});
    end
    wr(ADR_CTRL_EVEN, 32'hFFFF_FFFF);
    rd(ADR_CTRL_EVEN, q);
    `CHK(q, {16'h0000, CTRL_MASK_EVEN} & ~C_GATE);
    wr(ADR_CTRL_ODD, 32'hFFFF_FFFF);
    rd(ADR_CTRL_ODD, q);
    `CHK(q, {16'h0000, CTRL_MASK_ODD} & ~C_GATE);
    wr(ADR_CTRL_ODD, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_GATE);
    rd(ADR_CTRL_EVEN, q);
    `CHK(q, C_GATE);
    rd(8'h30, q);
    `CHK(q, 32'h0000_0000);
    // prescale: prescaler restarts at zero each enable
    for (int s = 0; s < 8; s++) begin
      wr(ADR_COUNT_EVEN, 32'h0000_0000);
      wr(ADR_CTRL_EVEN, C_ON | (32'(s) << PS_LSB));
      run(512);
      wr(ADR_CTRL_EVEN, 32'h0000_0000);
      rd(ADR_COUNT_EVEN, q);
      `CHK(in_rng(q, 512/divs[s] - 1, 512/divs[s] * 17/16 + 4), 1'b1);
    end
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    run(20);
    rd(ADR_COUNT_EVEN, q);
    `CHK(q, 32'h0000_0000);
    idle <= 1'b1;
    wr(ADR_CTRL_EVEN, C_ON | C_STOP_IN_IDLE_SEL);
    run(20);
    rd(ADR_COUNT_EVEN, q);
    `CHK(q, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_ON);
    run(20);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    rd(ADR_COUNT_EVEN, q);
    `CHK(in_rng(q, 20, 30), 1'b1);
    idle <= 1'b0;
    // external pin with gate enable set and gate low: must still count
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_ON | C_CS | C_GATE);
    repeat (5) begin
      ext_pin[0] <= 1'b1;
      run(3);
      ext_pin[0] <= 1'b0;
      run(3);
    end
    run(5);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    rd(ADR_COUNT_EVEN, q);
    `CHK(q, 32'h0000_0005);
    rd(ADR_INT_STATUS, q);
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_ON | C_GATE);
    run(10);
    gate_pin[0] <= 1'b1;
    run(20);
    gate_pin[0] <= 1'b0;
    run(6);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    rd(ADR_COUNT_EVEN, q);
    `CHK(in_rng(q, 18, 22), 1'b1);
    rd(ADR_INT_STATUS, q);
    `CHK(q, 32'h0000_0001);
    wr(ADR_PERIOD_EVEN, 32'h0000_0004);
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_ON);
    run(30);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    `CHK(irq, 1'b0);
    rd(ADR_COUNT_EVEN, q);
    `CHK(in_rng(q, 0, 4), 1'b1);
    wr(ADR_INT_MASK, 32'h0000_0001);
    run(2);
    `CHK(irq, 1'b1);
    rd(ADR_INT_STATUS, q);
    `CHK(q, 32'h0000_0001);
    run(2);
    `CHK(irq, 1'b0);
    rd(ADR_INT_STATUS, q);
    `CHK(q, 32'h0000_0000);
    // odd timer alone: own period, own status bit
    wr(ADR_PERIOD_ODD, 32'h0000_0003);
    wr(ADR_COUNT_ODD, 32'h0000_0000);
    wr(ADR_CTRL_ODD, C_ON);
    run(20);
    wr(ADR_CTRL_ODD, 32'h0000_0000);
    rd(ADR_COUNT_ODD, q);
    `CHK(in_rng(q, 0, 3), 1'b1);
    rd(ADR_INT_STATUS, q);
    `CHK(q, 32'h0000_0002);
    wr(ADR_PERIOD_ODD, 32'h0000_FFFF);
    wr(ADR_PERIOD_EVEN, 32'h0000_FFFF);
    // pair: odd enable, source and prescale must neither stop nor steer the pair; odd stop-in-idle stops it
    wr(ADR_COUNT_EVEN, 32'h0000_FFF0);
    wr(ADR_COUNT_ODD, 32'h0000_0000);
    wr(ADR_CTRL_ODD, C_ON | C_CS | (32'(7) << PS_LSB));
    wr(ADR_CTRL_EVEN, C_ON | C_WIDE);
    run(40);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    rd(ADR_COUNT_ODD, q);
    `CHK(q, 32'h0000_0001);
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    wr(ADR_CTRL_ODD, C_STOP_IN_IDLE_SEL);
    idle <= 1'b1;
    wr(ADR_CTRL_EVEN, C_ON | C_WIDE);
    run(20);
    rd(ADR_COUNT_EVEN, q);
    `CHK(q, 32'h0000_0000);
    // clearing the odd stop lets the pair run in idle
    wr(ADR_CTRL_ODD, 32'h0000_0000);
    run(20);
    rd(ADR_COUNT_EVEN, q);
    `CHK(in_rng(q, 20, 30), 1'b1);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    idle <= 1'b0;
    // pair period match reports on the odd flag only
    wr(ADR_PERIOD_EVEN, 32'h0000_0005);
    wr(ADR_PERIOD_ODD, 32'h0000_0000);
    wr(ADR_COUNT_EVEN, 32'h0000_0000);
    wr(ADR_COUNT_ODD, 32'h0000_0000);
    wr(ADR_CTRL_EVEN, C_ON | C_WIDE);
    run(20);
    wr(ADR_CTRL_EVEN, 32'h0000_0000);
    rd(ADR_INT_STATUS, q);
    `CHK(q, 32'h0000_0002);
    end_sim();
  end
endmodule // tb_type_b_timer_control

`undef CHK
`default_nettype wire
